// file: hw/nvmsd_pkg.sv
package nvmsd_pkg;
  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [3:0] IDX_COMMAND = 4'h0;
  localparam logic [3:0] IDX_PROTECT = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_INT_ENABLE = 4'h3;
  localparam logic [3:0] IDX_INT_FLAGS = 4'h4;
  localparam logic [3:0] IDX_RESERVED = 4'h5;
  localparam logic [3:0] IDX_DATA_LOW = 4'h6;
  localparam logic [3:0] IDX_DATA_HIGH = 4'h7;
  localparam logic [3:0] IDX_ADDR_LOW = 4'h8;
  localparam logic [3:0] IDX_ADDR_HIGH = 4'h9;
  localparam logic [3:0] IDX_ADDR_EXT = 4'hA;
  // ----------------------------------------
  // Field positions and codes
  // ----------------------------------------
  localparam int ERR_LSB = 4;
  localparam int ERR_MSB = 6;
  localparam int EE_BUSY_BIT = 1;
  localparam int FL_BUSY_BIT = 0;
  localparam int READY_BIT = 0;
  localparam int WP_CODE_BIT = 0;
  localparam int WP_DATA_BIT = 2;
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_UNSUPPORTED = 3'h1;
  localparam logic [2:0] ERR_PROTECTED = 3'h2;
  localparam logic [2:0] ERR_OVERLAP = 3'h3;
  localparam logic [6:0] CMD_IDLE = 7'h00;
  localparam logic [6:0] CMD_NULL_OP = 7'h01;
  localparam logic [6:0] CMD_CHIP_ERASE = 7'h20;
  localparam logic [6:0] CMD_EE_ERASE = 7'h30;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_COMMAND = 7'h00;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEC_BOOT = 2'h0,
    SEC_APP_CODE = 2'h1,
    SEC_APP_DATA = 2'h2,
    SEC_EEPROM = 2'h3
  } nvmsd_section_t;
  typedef struct packed {
    logic valid;
    nvmsd_section_t section;
    logic [23:0] addr;
    logic [15:0] data;
  } nvmsd_access_t;
  typedef struct packed {
    logic start;
    logic [6:0] command;
    logic [23:0] addr;
    logic [15:0] data;
  } nvmsd_prog_t;
endpackage

// file: hw/nvmsd_regs.sv
`timescale 1ns/1ps
// Behaviour
// [RL1] Status bits 6:4 hold the most recent error code; zero means none.
// [RL2] Software writing zero into the error field returns it to no-error.
// [RL3] Selecting an unsupported command loads error code one.
// [RL4] Store to a write-protected section is dropped and loads error code two; code sets it only while a write or erase command is selected.
// [RL5] New write or erase command during an ongoing one loads error three.
// [RL6] Status bit 1 is read-only and shows EEPROM programming in progress.
// [RL7] Status bit 0 is read-only and shows flash programming in progress.
// [RL8] Bit 0 at index 0x03 enables the EEPROM-ready interrupt.
// [RL9] Interrupt request is a level: ready flag and its enable both set.
// [RL10] Software enables the ready interrupt only after issuing an EEPROM command.
// [RL11] The interrupt handler clears the enable bit to stop the level request.
// [RL12] Bit 0 at index 0x04 is set by hardware while EEPROM is idle.
// [RL13] Writing one clears the ready flag; writing zero leaves it.
// [RL14] Sixteen-bit data value: low byte at 0x06, high byte at 0x07.
// [RL15] Data value captures the latest read from flash, EEPROM or controller.
// [RL16] EEPROM accesses use only the low data byte; high byte is untouched.
// [RL17] 24-bit address in three bytes at 0x08, 0x09 and 0x0A.
// [RL18] Address value holds the most recently accessed memory location.
// [RL19] Software passes through idle or null command between two commands.
// [RL20] After reset enable, flag, data and address read zero, error none; the flag reads one once the idle EEPROM sets it a cycle later.
module nvmsd_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic flash_busy_in,
  input wire logic eeprom_busy_in,
  input wire nvmsd_pkg::nvmsd_access_t store_in,
  input wire nvmsd_pkg::nvmsd_access_t read_in,
  output nvmsd_pkg::nvmsd_prog_t prog_out,
  output logic irq_out
);
  import nvmsd_pkg::*;

  // Decode needs index bits 5:2 below the upper address bits
  if (ADDR_W < 6) begin : g_addr_w_check
    $error("ADDR_W must be at least 6");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [6:0] command_reg;
  logic wp_code_reg;
  logic wp_data_reg;
  logic [2:0] error_reg;
  logic int_enable_reg;
  logic ready_flag_reg;
  logic [15:0] data_reg;
  logic [23:0] addr_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  nvmsd_prog_t prog_reg;
  logic [2:0] error_next;
  logic [15:0] data_next;
  logic [23:0] addr_next;
  logic ready_flag_next;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Two-cycle access phase so read data leaves a flop
  wire logic [3:0] reg_index = paddr_in[5:2];
  wire logic addr_mapped = (paddr_in[ADDR_W-1:6] == '0) && (reg_index <= IDX_ADDR_EXT);
  wire logic access_done = psel_in && penable_in && pready_reg;
  wire logic bus_wr = access_done && pwrite_in && addr_mapped;
  wire logic wr_command = bus_wr && (reg_index == IDX_COMMAND);
  wire logic wr_protect = bus_wr && (reg_index == IDX_PROTECT);
  wire logic wr_status = bus_wr && (reg_index == IDX_STATUS);
  wire logic wr_int_enable = bus_wr && (reg_index == IDX_INT_ENABLE);
  wire logic wr_int_flags = bus_wr && (reg_index == IDX_INT_FLAGS);
  wire logic wr_data_low = bus_wr && (reg_index == IDX_DATA_LOW);
  wire logic wr_data_high = bus_wr && (reg_index == IDX_DATA_HIGH);
  wire logic wr_addr_low = bus_wr && (reg_index == IDX_ADDR_LOW);
  wire logic wr_addr_high = bus_wr && (reg_index == IDX_ADDR_HIGH);
  wire logic wr_addr_ext = bus_wr && (reg_index == IDX_ADDR_EXT);
  wire logic [7:0] wbyte = pwdata_in[7:0];

  // ----------------------------------------
  // Command checks
  // ----------------------------------------
  function automatic logic cmd_supported(input logic [6:0] c);
    case (c)
      7'h00, 7'h01, 7'h02, 7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h0D,
      7'h12, 7'h13, 7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D,
      7'h20, 7'h30: cmd_supported = 1'b1;
      default: cmd_supported = 1'b0;
    endcase
  endfunction

  wire logic [6:0] new_cmd = wbyte[6:0];
  wire logic new_is_op = (new_cmd != CMD_IDLE) && (new_cmd != CMD_NULL_OP);
  wire logic cur_is_op = (command_reg != CMD_IDLE) && (command_reg != CMD_NULL_OP);
  wire logic any_busy = flash_busy_in || eeprom_busy_in;
  wire logic cmd_bad = wr_command && !cmd_supported(new_cmd); // see [RL3]
  // Skipping the idle step between two commands counts as overlap too
  wire logic cmd_overlap = wr_command && cmd_supported(new_cmd) && new_is_op &&
    (any_busy || (cur_is_op && (new_cmd != command_reg))); // see [RL5] see [RL19]
  wire logic cmd_ok = wr_command && cmd_supported(new_cmd) && !cmd_overlap;
  wire logic immediate_erase = cmd_ok && ((new_cmd == CMD_CHIP_ERASE) || (new_cmd == CMD_EE_ERASE));
  wire logic sec_locked = ((store_in.section == SEC_APP_CODE) && wp_code_reg) ||
    ((store_in.section == SEC_APP_DATA) && wp_data_reg);
  wire logic store_blocked = store_in.valid && cur_is_op && sec_locked; // see [RL4]
  wire logic store_go = store_in.valid && cur_is_op && !sec_locked;
  wire logic read_hit = read_in.valid;
  wire logic read_ee = read_in.section == SEC_EEPROM;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  // Hardware errors win over a software clear in the same cycle
  always_comb begin
    if (cmd_bad) begin
      error_next = ERR_UNSUPPORTED; // see [RL3]
    end else if (cmd_overlap) begin
      error_next = ERR_OVERLAP; // see [RL5]
    end else if (store_blocked) begin
      error_next = ERR_PROTECTED; // see [RL4]
    end else if (wr_status) begin
      error_next = wbyte[ERR_MSB:ERR_LSB]; // see [RL2]
    end else begin
      error_next = error_reg; // see [RL1]
    end
  end

  // Idle EEPROM keeps setting the flag, so a clear only sticks while busy
  assign ready_flag_next = !eeprom_busy_in ||
    (ready_flag_reg && !(wr_int_flags && wbyte[READY_BIT])); // see [RL12] see [RL13]

  always_comb begin
    data_next = data_reg;
    if (read_hit) begin
      data_next[7:0] = read_in.data[7:0]; // see [RL15]
      if (!read_ee) begin
        data_next[15:8] = read_in.data[15:8]; // see [RL16]
      end
    end else begin
      if (wr_data_low) begin
        data_next[7:0] = wbyte;
      end
      if (wr_data_high) begin
        data_next[15:8] = wbyte;
      end
    end
  end

  always_comb begin
    addr_next = addr_reg;
    if (read_hit) begin
      addr_next = read_in.addr; // see [RL18]
    end else if (store_in.valid) begin
      addr_next = store_in.addr; // see [RL18]
    end else begin
      if (wr_addr_low) begin
        addr_next[7:0] = wbyte; // see [RL17]
      end
      if (wr_addr_high) begin
        addr_next[15:8] = wbyte;
      end
      if (wr_addr_ext) begin
        addr_next[23:16] = wbyte;
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = RST_BYTE;
    if (reg_index == IDX_COMMAND) begin
      rd_byte = {1'b0, command_reg};
    end else if (reg_index == IDX_PROTECT) begin
      rd_byte = {5'h00, wp_data_reg, 1'b0, wp_code_reg};
    end else if (reg_index == IDX_STATUS) begin
      rd_byte = {1'b0, error_reg, 2'h0, eeprom_busy_in, flash_busy_in}; // see [RL6] see [RL7]
    end else if (reg_index == IDX_INT_ENABLE) begin
      rd_byte = {7'h00, int_enable_reg};
    end else if (reg_index == IDX_INT_FLAGS) begin
      rd_byte = {7'h00, ready_flag_reg};
    end else if (reg_index == IDX_DATA_LOW) begin
      rd_byte = data_reg[7:0]; // see [RL14]
    end else if (reg_index == IDX_DATA_HIGH) begin
      rd_byte = data_reg[15:8];
    end else if (reg_index == IDX_ADDR_LOW) begin
      rd_byte = addr_reg[7:0];
    end else if (reg_index == IDX_ADDR_HIGH) begin
      rd_byte = addr_reg[15:8];
    end else if (reg_index == IDX_ADDR_EXT) begin
      rd_byte = addr_reg[23:16];
    end
  end

  // ----------------------------------------
  // Bus flops
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= psel_in && penable_in && !pready_reg;
      pslverr_reg <= psel_in && penable_in && !pready_reg && !addr_mapped;
      prdata_reg <= (psel_in && penable_in && !pready_reg && addr_mapped && !pwrite_in) ?
        {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ----------------------------------------
  // Register flops
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      command_reg <= RST_COMMAND;
      wp_code_reg <= 1'b0;
      wp_data_reg <= 1'b0;
      error_reg <= ERR_NONE; // see [RL20]
      int_enable_reg <= 1'b0;
      ready_flag_reg <= 1'b0;
      data_reg <= 16'h0000;
      addr_reg <= 24'h000000;
      irq_reg <= 1'b0;
      prog_reg <= '0;
    end else begin
      if (cmd_ok) begin
        command_reg <= new_cmd;
      end
      // Protection only sets; reset is the only way out
      if (wr_protect) begin
        wp_code_reg <= wp_code_reg | wbyte[WP_CODE_BIT];
        wp_data_reg <= wp_data_reg | wbyte[WP_DATA_BIT];
      end
      if (wr_int_enable) begin
        int_enable_reg <= wbyte[READY_BIT]; // see [RL8] see [RL11]
      end
      error_reg <= error_next;
      ready_flag_reg <= ready_flag_next;
      data_reg <= data_next;
      addr_reg <= addr_next;
      irq_reg <= ready_flag_reg && int_enable_reg; // see [RL9] see [RL10]
      prog_reg.start <= store_go || immediate_erase;
      prog_reg.command <= immediate_erase ? new_cmd : command_reg;
      prog_reg.addr <= store_in.addr;
      prog_reg.data <= store_in.data;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign irq_out = irq_reg;
  assign prog_out = prog_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_bad_cmd_write;
    wr_command && !cmd_supported(new_cmd);
  endsequence
  sequence s_overlap_write;
    wr_command && cmd_supported(new_cmd) && new_is_op && any_busy;
  endsequence

  property p_err_unsupported;
    s_bad_cmd_write |=> (error_reg == ERR_UNSUPPORTED) && $stable(command_reg);
  endproperty
  a_err_unsupported: assert property (p_err_unsupported) else $error("unsupported command not flagged"); // see [RL3]

  property p_err_overlap;
    s_overlap_write |=> (error_reg == ERR_OVERLAP) && (command_reg == $past(command_reg));
  endproperty
  a_err_overlap: assert property (p_err_overlap) else $error("overlapping command not flagged"); // see [RL5]

  property p_err_protect;
    (store_in.valid && cur_is_op && sec_locked && !wr_command) |=>
      (error_reg == ERR_PROTECTED) && !prog_out.start;
  endproperty
  a_err_protect: assert property (p_err_protect) else $error("protected store not refused"); // see [RL4]

  property p_err_clear;
    (wr_status && (wbyte[ERR_MSB:ERR_LSB] == ERR_NONE) && !wr_command && !store_in.valid) |=>
      (error_reg == ERR_NONE);
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error field not cleared"); // see [RL2]

  property p_busy_view;
    (psel_in && penable_in && !pready_reg && !pwrite_in && (reg_index == IDX_STATUS) && addr_mapped) |=>
      (prdata_out[EE_BUSY_BIT] == $past(eeprom_busy_in)) && (prdata_out[FL_BUSY_BIT] == $past(flash_busy_in));
  endproperty
  a_busy_view: assert property (p_busy_view) else $error("busy bits wrong on status read"); // see [RL6] see [RL7]

  property p_flag_idle;
    !eeprom_busy_in |=> ready_flag_reg ##1 (irq_out == int_enable_reg || !$stable(int_enable_reg));
  endproperty
  a_flag_idle: assert property (p_flag_idle) else $error("ready flag missing while idle"); // see [RL12]

  property p_flag_clear;
    (eeprom_busy_in && wr_int_flags && wbyte[READY_BIT]) |=> !ready_flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("ready flag not cleared by one"); // see [RL13]

  property p_irq_level;
    irq_out == $past(ready_flag_reg && int_enable_reg);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch"); // see [RL9]

  property p_data_ee;
    (read_in.valid && read_ee) |=> (data_reg[7:0] == $past(read_in.data[7:0])) && $stable(data_reg[15:8]);
  endproperty
  a_data_ee: assert property (p_data_ee) else $error("EEPROM read disturbed high byte"); // see [RL15] see [RL16]

  property p_addr_last;
    read_in.valid |=> (addr_reg == $past(read_in.addr));
  endproperty
  a_addr_last: assert property (p_addr_last) else $error("address not captured"); // see [RL18]

  property p_enable_write;
    wr_int_enable |=> (int_enable_reg == $past(wbyte[READY_BIT]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not written"); // see [RL8]

  property p_err_hold;
    (!wr_command && !store_in.valid && !wr_status) |=> (error_reg == $past(error_reg));
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error field changed without cause"); // see [RL1]

  property p_flag_keep;
    (eeprom_busy_in && ready_flag_reg && !(wr_int_flags && wbyte[READY_BIT])) |=> ready_flag_reg;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("ready flag lost without a clear"); // see [RL13]

  property p_data_flash;
    (read_in.valid && !read_ee) |=> (data_reg == $past(read_in.data));
  endproperty
  a_data_flash: assert property (p_data_flash) else $error("flash read not captured"); // see [RL15]

  property p_data_high_write;
    (wr_data_high && !read_in.valid) |=> (data_reg[15:8] == $past(wbyte));
  endproperty
  a_data_high_write: assert property (p_data_high_write) else $error("data high byte not written"); // see [RL14]

  property p_addr_ext_write;
    (wr_addr_ext && !read_in.valid && !store_in.valid) |=>
      (addr_reg[23:16] == $past(wbyte)) && $stable(addr_reg[15:0]);
  endproperty
  a_addr_ext_write: assert property (p_addr_ext_write) else $error("extended address byte wrong"); // see [RL17]

  property p_store_start;
    (store_in.valid && cur_is_op && !sec_locked) |=> prog_out.start && (prog_out.addr == $past(store_in.addr));
  endproperty
  a_store_start: assert property (p_store_start) else $error("open store did not start"); // see [RL4]

  property p_store_addr;
    (store_in.valid && !read_in.valid) |=> (addr_reg == $past(store_in.addr));
  endproperty
  a_store_addr: assert property (p_store_addr) else $error("store address not captured"); // see [RL18]

  property p_irq_needs_enable;
    !int_enable_reg |=> !irq_out;
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("interrupt without enable"); // see [RL9]

endmodule // nvmsd_regs

// file: verif/nvmsd_mem_model.sv
`timescale 1ns/1ps
module nvmsd_mem_model #(
  parameter int BUSY_CYC = 60
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire nvmsd_pkg::nvmsd_prog_t prog_in,
  input wire nvmsd_pkg::nvmsd_access_t req_in,
  output logic flash_busy_out,
  output logic eeprom_busy_out,
  output nvmsd_pkg::nvmsd_access_t read_out
);
  import nvmsd_pkg::*;
  int cnt_reg;
  // ----------------------------------------
  // Array timing
  // ----------------------------------------
  // Bit 4 of the command picks EEPROM; chip erase is treated as flash only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= 0;
      flash_busy_out <= 1'h0;
      eeprom_busy_out <= 1'h0;
      read_out <= '0;
    end else begin
      if (prog_in.start) begin
        cnt_reg <= BUSY_CYC;
        eeprom_busy_out <= prog_in.command[4];
        flash_busy_out <= !prog_in.command[4];
      end else if (cnt_reg > 1) begin
        cnt_reg <= cnt_reg - 1;
      end else begin
        cnt_reg <= 0;
        flash_busy_out <= 1'h0;
        eeprom_busy_out <= 1'h0;
      end
      read_out.valid <= req_in.valid;
      read_out.section <= req_in.section;
      read_out.addr <= req_in.addr;
      // Stale data flips between answers so it is never mistaken for a reply
      read_out.data <= req_in.valid ? (req_in.addr[15:0] ^ 16'h5A3C) : ~read_out.data;
    end
  end
endmodule // nvmsd_mem_model

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import nvmsd_pkg::*;
  logic clk_in, rst_in, psel, penable, pwrite, pready, pslverr, fl_busy, ee_busy, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] a;
  logic [15:0] w;
  logic [7:0] hi, wd;
  nvmsd_access_t store, rd_req, rd_resp;
  nvmsd_prog_t prog, last_prog;
  int n_errors = 0;
  int n_compared = 0;
  int n_start = 0;
  int s0;

  nvmsd_regs #(.ADDR_W(12)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .flash_busy_in(fl_busy), .eeprom_busy_in(ee_busy), .store_in(store),
    .read_in(rd_resp), .prog_out(prog), .irq_out(irq));
  nvmsd_mem_model #(.BUSY_CYC(60)) u_mem (.clk_in(clk_in), .rst_in(rst_in), .prog_in(prog),
    .req_in(rd_req), .flash_busy_out(fl_busy), .eeprom_busy_out(ee_busy), .read_out(rd_resp));

  initial begin
    clk_in = 1'h0;
    forever #12.5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (prog.start === 1'h1) begin
      n_start <= n_start + 1;
      last_prog <= prog;
    end
  end

  function automatic logic [7:0] exp_status(input logic [2:0] err, input logic eb, input logic fb);
    return {1'h0, err, 2'h0, eb, fb};
  endfunction

  function automatic logic [15:0] exp_word(input logic [23:0] ad);
    return ad[15:0] ^ 16'h5A3C;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Bus and event drivers
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] data);
    int n;
    @(posedge clk_in);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {6'h00, idx, 2'h0};
    pwdata <= {24'h000000, data};
    @(posedge clk_in);
    penable <= 1'h1;
    n = 0;
    @(posedge clk_in);
    while (pready !== 1'h1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= 20) begin
      check(32'h0, 32'h1);
      wrap_up();
    end
    // Taken at the edge where pready is seen high, then released
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rchk(input logic [3:0] idx, input logic [7:0] exp);
    apb(1'h0, idx, 8'h00);
    check(rd, {24'h000000, exp});
  endtask

  task automatic ev(input logic st, input nvmsd_section_t s, input logic [23:0] ad);
    @(posedge clk_in);
    if (st) store <= '{valid: 1'h1, section: s, addr: ad, data: 16'h1234};
    else rd_req <= '{valid: 1'h1, section: s, addr: ad, data: 16'h0000};
    @(posedge clk_in);
    store.valid <= 1'h0;
    rd_req.valid <= 1'h0;
    repeat (2) @(posedge clk_in);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_in = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    store = '0;
    rd_req = '0;
    void'($urandom(85590));
    repeat (16) @(posedge clk_in);
    rst_in <= 1'h0;
    rchk(IDX_STATUS, exp_status(ERR_NONE, 1'h0, 1'h0));
    rchk(IDX_INT_ENABLE, 8'h00);
    rchk(IDX_INT_FLAGS, 8'h01);
    for (int i = 6; i <= 10; i++) rchk(4'(i), 8'h00);
    apb(1'h0, 4'hB, 8'h00);
    check(rd, 32'h00000000);
    check({31'h0, er}, 32'h00000001);
    for (int i = 6; i <= 10; i++) begin
      wd = 8'($urandom);
      apb(1'h1, 4'(i), wd);
      rchk(4'(i), wd);
    end
    apb(1'h1, IDX_COMMAND, 8'h7F);
    rchk(IDX_STATUS, exp_status(ERR_UNSUPPORTED, 1'h0, 1'h0));
    apb(1'h1, IDX_STATUS, 8'h00);
    rchk(IDX_STATUS, exp_status(ERR_NONE, 1'h0, 1'h0));
    apb(1'h1, IDX_COMMAND, {1'h0, CMD_IDLE});
    s0 = n_start;
    apb(1'h1, IDX_COMMAND, {1'h0, CMD_EE_ERASE});
    apb(1'h1, IDX_INT_ENABLE, 8'h01);
    apb(1'h1, IDX_INT_FLAGS, 8'h01);
    rchk(IDX_INT_FLAGS, 8'h00);
    @(negedge clk_in);
    check({31'h0, irq}, 32'h0);
    check(n_start, s0 + 1);
    check({25'h0, last_prog.command}, {25'h0, CMD_EE_ERASE});
    apb(1'h1, IDX_COMMAND, {1'h0, CMD_CHIP_ERASE});
    rchk(IDX_STATUS, exp_status(ERR_OVERLAP, 1'h1, 1'h0));
    for (int n = 0; n < 200 && irq !== 1'h1; n++) @(negedge clk_in);
    check({31'h0, irq}, 32'h1);
    if (irq !== 1'h1) wrap_up();
    apb(1'h1, IDX_INT_FLAGS, 8'h00);
    rchk(IDX_INT_FLAGS, 8'h01);
    apb(1'h1, IDX_INT_ENABLE, 8'h00);
    repeat (2) @(negedge clk_in);
    check({31'h0, irq}, 32'h0);
    apb(1'h1, IDX_STATUS, 8'h00);
    apb(1'h1, IDX_COMMAND, {1'h0, CMD_IDLE});
    apb(1'h1, IDX_PROTECT, 8'h01);
    apb(1'h1, IDX_COMMAND, 8'h02);
    a = 24'($urandom);
    s0 = n_start;
    ev(1'h1, SEC_APP_CODE, a);
    check(n_start, s0);
    rchk(IDX_STATUS, exp_status(ERR_PROTECTED, 1'h0, 1'h0));
    apb(1'h1, IDX_STATUS, 8'h00);
    ev(1'h1, SEC_APP_DATA, a);
    check(n_start, s0 + 1);
    check({25'h0, last_prog.command}, 32'h00000002);
    check({8'h00, last_prog.addr}, {8'h00, a});
    check({16'h0000, last_prog.data}, 32'h00001234);
    rchk(IDX_STATUS, exp_status(ERR_NONE, 1'h0, 1'h1));
    rchk(IDX_ADDR_LOW, a[7:0]);
    rchk(IDX_ADDR_HIGH, a[15:8]);
    rchk(IDX_ADDR_EXT, a[23:16]);
    hi = 8'($urandom);
    apb(1'h1, IDX_DATA_HIGH, hi);
    a = 24'($urandom);
    w = exp_word(a);
    ev(1'h0, SEC_EEPROM, a);
    rchk(IDX_DATA_LOW, w[7:0]);
    rchk(IDX_DATA_HIGH, hi);
    rchk(IDX_ADDR_LOW, a[7:0]);
    a = 24'($urandom);
    w = exp_word(a);
    ev(1'h0, SEC_APP_CODE, a);
    rchk(IDX_DATA_LOW, w[7:0]);
    rchk(IDX_DATA_HIGH, w[15:8]);
    rchk(IDX_ADDR_EXT, a[23:16]);
    // Store with no command selected only moves the address
    apb(1'h1, IDX_COMMAND, {1'h0, CMD_IDLE});
    a = 24'($urandom);
    s0 = n_start;
    ev(1'h1, SEC_BOOT, a);
    check(n_start, s0);
    rchk(IDX_ADDR_HIGH, a[15:8]);
    wrap_up();
  end
endmodule // testbench
